/* File: plc_defs.svh */
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH
// Link speed codes
`define PLC_SPD_S100      2'h0
`define PLC_SPD_S200      2'h1
`define PLC_SPD_S400      2'h2
`define PLC_LSPD_RESET    2'h2
// Extended request speed codes, S400 is the top supported
`define PLC_XSPD_S400     3'h2
// Request framing
`define PLC_REQ_LEN_LEG   4'h7
`define PLC_REQ_LEN_EXT   4'h8
`define PLC_REQ_TYPE_W    3
`define PLC_TYPE_BUS      3'h1
`define PLC_TYPE_RDREG    3'h5
`define PLC_TYPE_WRREG    3'h6
// Register write request length (start + type + addr + data)
`define PLC_REQ_LEN_WR    5'h11
`define PLC_REQ_LEN_RD    5'h9
`define PLC_REQ_LEN_OTH   5'h7
`endif

/* File: plc_pkg.sv */
package plc_pkg;
  typedef enum logic [1:0] {
    PLC_ST_IDLE,
    PLC_ST_SHIFT,
    PLC_ST_DONE
  } plc_rx_state_t;
  typedef enum logic [1:0] {
    PLC_TX_IDLE,
    PLC_TX_PREFIX,
    PLC_TX_END
  } plc_tx_state_t;
endpackage : plc_pkg

/* File: plc_sync.sv */
`timescale 1ns/10ps
module plc_sync (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // Async pin in, delayed level out
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // The request line is launched on this clock, so the stages only delay it.
  // An agreement filter here would swallow the one-cycle bits of a request.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg    <= s2_reg;
      level_out <= s3_reg;
    end
  end
endmodule : plc_sync

/* File: plc_link_compat.sv */
// Function
// - Decode 7-bit legacy and 8-bit extended bus requests from request line.
// - A legacy request followed at once by another request decodes both.
// - Extended request with speed above S400 sends a null packet.
// - All received data passes to link, no speed filtering.
// - Link speed field only changes self-ID speed value.
// - Peers always see S400 capability during self-ID.
// - Link speed field is S400 after power-on.
// - Link speed is two bits: 00 S100, 01 S200, 10 S400, 11 invalid.
// - Link speed loads S400 on hardware reset, kept over bus reset.
`timescale 1ns/10ps
`include "plc_defs.svh"
module plc_link_compat (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Serial request line from link
  input  wire logic       link_req_in,
  // Request length mode: 1 extended 8-bit, 0 legacy 7-bit bus requests
  input  wire logic       ext_req_mode_in,
  // Link speed field write port
  input  wire logic       lspd_wr_in,
  input  wire logic [1:0] lspd_wdata_in,
  // Feature enables held by software
  input  wire logic       arb_accel_enable_in,
  input  wire logic       multispeed_concat_enable_in,
  // Receive path from cable
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_data_in,
  // Decoded request
  output logic            req_valid_out,
  output logic [2:0]      req_type_out,
  output logic [2:0]      req_speed_out,
  output logic [11:0]     req_payload_out,
  // Null packet transmit
  output logic            tx_prefix_out,
  output logic            tx_end_out,
  // Self-ID speed fields
  output logic [1:0]      selfid_sp_out,
  output logic [1:0]      peer_speed_out,
  // Data to link
  output logic            link_rx_valid_out,
  output logic [7:0]      link_rx_data_out,
  // Feature enables as applied
  output logic            arb_accel_active_out,
  output logic            multispeed_concat_active_out
);
  // ***********************************************
  // Request line capture
  // ***********************************************
  logic req_line;
  plc_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .pin_in     (link_req_in),
    .level_out  (req_line)
  );

  plc_pkg::plc_rx_state_t rx_st_reg;
  plc_pkg::plc_rx_state_t rx_st_next;
  logic [4:0]  cnt_reg;
  logic [16:0] sh_reg;
  logic [4:0]  req_len;
  logic [2:0]  type_bits;
  logic        last_bit;
  logic [16:0] sh_next;
  logic [2:0]  type_reg;

  // Request type is latched once the third bit after the start bit is in,
  // since the shifter keeps moving and would lose it
  assign sh_next   = {sh_reg[15:0], req_line};
  assign type_bits = type_reg;
  assign req_len   = (type_bits == `PLC_TYPE_WRREG) ? `PLC_REQ_LEN_WR :
                     (type_bits == `PLC_TYPE_RDREG) ? `PLC_REQ_LEN_RD :
                     (type_bits == `PLC_TYPE_BUS && ext_req_mode_in) ?
                       {1'b0, `PLC_REQ_LEN_EXT} - 5'h1 + 5'h1 :
                     `PLC_REQ_LEN_OTH;
  // Counter holds bits captured after the start bit
  assign last_bit  = (rx_st_reg == plc_pkg::PLC_ST_SHIFT) && (cnt_reg + 5'h2 == req_len);

  always_comb begin
    rx_st_next = rx_st_reg;
    case (rx_st_reg)
      plc_pkg::PLC_ST_IDLE: begin
        if (req_line) begin
          rx_st_next = plc_pkg::PLC_ST_SHIFT;
        end
      end
      plc_pkg::PLC_ST_SHIFT: begin
        if (last_bit) begin
          rx_st_next = plc_pkg::PLC_ST_DONE;
        end
      end
      // back-to-back: done lasts one cycle, next start bit may follow
      plc_pkg::PLC_ST_DONE: begin
        rx_st_next = req_line ? plc_pkg::PLC_ST_SHIFT : plc_pkg::PLC_ST_IDLE;
      end
      default: begin
        rx_st_next = plc_pkg::PLC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_st_reg <= plc_pkg::PLC_ST_IDLE;
      cnt_reg   <= 5'h0;
      sh_reg    <= 17'h0;
      type_reg  <= 3'h0;
    end else begin
      rx_st_reg <= rx_st_next;
      if (rx_st_reg == plc_pkg::PLC_ST_SHIFT) begin
        sh_reg  <= sh_next;
        cnt_reg <= cnt_reg + 5'h1;
        if (cnt_reg == 5'h2) begin
          type_reg <= sh_next[2:0];
        end
      end else begin
        sh_reg  <= 17'h0;
        cnt_reg <= 5'h0;
      end
    end
  end

  // ***********************************************
  // Request decode
  // ***********************************************
  logic        bus_req;
  logic [2:0]  speed_dec;
  logic        fin;
  logic [4:0]  total;
  logic [16:0] fullw;
  assign fin   = last_bit;
  assign total = req_len - 5'h1;
  assign fullw = sh_next;
  assign bus_req = (type_bits == `PLC_TYPE_BUS);
  // legacy 2-bit speed is the low end of the 3-bit code space
  assign speed_dec = ext_req_mode_in ? fullw[2:0] : {1'b0, fullw[1:0]};

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_valid_out   <= 1'b0;
      req_type_out    <= 3'h0;
      req_speed_out   <= 3'h0;
      req_payload_out <= 12'h0;
    end else begin
      req_valid_out <= fin;
      if (fin) begin
        req_type_out    <= type_bits;
        req_speed_out   <= bus_req ? speed_dec : 3'h0;
        req_payload_out <= (total > 5'h7) ? fullw[11:0] : {8'h0, fullw[3:0]};
      end
    end
  end

  // ***********************************************
  // Null packet for unsupported speed
  // ***********************************************
  plc_pkg::plc_tx_state_t tx_st_reg;
  logic                   null_req;
  // speed above S400 answered with prefix then end
  assign null_req = fin && bus_req && ext_req_mode_in && (speed_dec > `PLC_XSPD_S400);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_st_reg     <= plc_pkg::PLC_TX_IDLE;
      tx_prefix_out <= 1'b0;
      tx_end_out    <= 1'b0;
    end else begin
      case (tx_st_reg)
        plc_pkg::PLC_TX_IDLE: begin
          tx_end_out <= 1'b0;
          if (null_req) begin
            tx_st_reg     <= plc_pkg::PLC_TX_PREFIX;
            tx_prefix_out <= 1'b1;
          end
        end
        plc_pkg::PLC_TX_PREFIX: begin
          tx_st_reg     <= plc_pkg::PLC_TX_END;
          tx_prefix_out <= 1'b0;
          tx_end_out    <= 1'b1;
        end
        default: begin
          tx_st_reg  <= plc_pkg::PLC_TX_IDLE;
          tx_end_out <= 1'b0;
        end
      endcase
    end
  end

  // ***********************************************
  // Link speed field and self-ID
  // ***********************************************
  logic [1:0] lspd_reg;
  logic       lspd_ok;
  // code 11 rejected, field keeps its old value
  assign lspd_ok = lspd_wr_in && (lspd_wdata_in != 2'h3);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lspd_reg       <= `PLC_LSPD_RESET;
      selfid_sp_out  <= `PLC_LSPD_RESET;
      peer_speed_out <= `PLC_SPD_S400;
    end else begin
      if (lspd_ok) begin
        lspd_reg <= lspd_wdata_in;
      end
      // only the self-ID speed value follows the field
      selfid_sp_out  <= lspd_reg;
      peer_speed_out <= `PLC_SPD_S400;
    end
  end

  // ***********************************************
  // Receive forwarding and feature enables
  // ***********************************************
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_rx_valid_out            <= 1'b0;
      link_rx_data_out             <= 8'h0;
      arb_accel_active_out         <= 1'b0;
      multispeed_concat_active_out <= 1'b0;
    end else begin
      link_rx_valid_out            <= rx_valid_in;
      link_rx_data_out             <= rx_data_in;
      arb_accel_active_out         <= arb_accel_enable_in;
      multispeed_concat_active_out <= multispeed_concat_enable_in;
    end
  end
endmodule : plc_link_compat

/* File: plc_link_compat_sva.sv */
`timescale 1ns/10ps
`include "plc_defs.svh"
module plc_link_compat_sva (
  // Clock and reset
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  // Inputs watched
  input wire logic       ext_req_mode_in,
  input wire logic       lspd_wr_in,
  input wire logic [1:0] lspd_wdata_in,
  input wire logic       rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic       arb_accel_enable_in,
  // Outputs watched
  input wire logic       req_valid_out,
  input wire logic [2:0] req_type_out,
  input wire logic [2:0] req_speed_out,
  input wire logic       tx_prefix_out,
  input wire logic       tx_end_out,
  input wire logic [1:0] selfid_sp_out,
  input wire logic [1:0] peer_speed_out,
  input wire logic       link_rx_valid_out,
  input wire logic [7:0] link_rx_data_out,
  input wire logic       arb_accel_active_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_null_pair: assert property (tx_prefix_out |=> tx_end_out && !tx_prefix_out)
    else $error("null packet end missing");
  a_null_cause: assert property (req_valid_out && $past(ext_req_mode_in)
    && req_type_out == `PLC_TYPE_BUS && req_speed_out > `PLC_XSPD_S400 |-> tx_prefix_out)
    else $error("no null packet");
  a_null_only: assert property (tx_prefix_out |-> req_valid_out
    && req_type_out == `PLC_TYPE_BUS && req_speed_out > `PLC_XSPD_S400)
    else $error("stray null packet");
  a_peer_fixed: assert property (peer_speed_out == `PLC_SPD_S400)
    else $error("peer speed not S400");
  a_selfid_follow: assert property (lspd_wr_in && lspd_wdata_in != 2'h3
    |=> ##1 selfid_sp_out == $past(lspd_wdata_in, 2)) else $error("self-ID speed wrong");
  a_bad_code: assert property (lspd_wr_in && lspd_wdata_in == 2'h3 ##1 !lspd_wr_in
    |=> $stable(selfid_sp_out)) else $error("reserved code taken");
  a_rx_forward: assert property (rx_valid_in |=> link_rx_valid_out
    && link_rx_data_out == $past(rx_data_in)) else $error("rx byte lost");
  a_rx_quiet: assert property (!rx_valid_in |=> !link_rx_valid_out)
    else $error("rx byte invented");
  a_accel_pass: assert property (arb_accel_active_out == $past(arb_accel_enable_in))
    else $error("accel enable not passed");
  cover property (tx_prefix_out);
  cover property (req_valid_out && req_type_out == `PLC_TYPE_WRREG);
  cover property (lspd_wr_in && lspd_wdata_in == 2'h3);
endmodule : plc_link_compat_sva
bind plc_link_compat plc_link_compat_sva chk_u (.*);

/* File: plc_link_model.sv */
`timescale 1ns/10ps
module plc_link_model (
  // Clock
  input wire logic ref_clk_in,
  // Request line
  output logic     link_req_out
);
  initial link_req_out = 1'b0;
  // last bit stands so a next request can follow at once
  task automatic send(input logic [16:0] bits, input int len);
    @(posedge ref_clk_in);
    for (int i = len - 1; i >= 0; i--) begin
      link_req_out <= bits[i];
      if (i > 0) @(posedge ref_clk_in);
    end
  endtask : send
  task automatic idle;
    @(posedge ref_clk_in);
    link_req_out <= 1'b0;
  endtask : idle
endmodule : plc_link_model

/* File: tb_phy_link_compat_and_speed_report.sv */
`timescale 1ns/10ps
`include "plc_defs.svh"
module tb_phy_link_compat_and_speed_report;
  logic ref_clk_in = 0, rst_in = 1, link_req_in, ext_req_mode_in = 0, lspd_wr_in = 0;
  logic arb_accel_enable_in = 0, multispeed_concat_enable_in = 0, rx_valid_in = 0;
  logic [1:0] lspd_wdata_in = 0, selfid_sp_out, peer_speed_out;
  logic [7:0] rx_data_in = 0, link_rx_data_out;
  logic req_valid_out, tx_prefix_out, tx_end_out, link_rx_valid_out;
  logic arb_accel_active_out, multispeed_concat_active_out;
  logic [2:0] req_type_out, req_speed_out;
  logic [11:0] req_payload_out;
  logic [17:0] got[$];
  int n_errors = 0, comparisons = 0, n_null = 0;
  plc_link_compat dut_u (.*);
  plc_link_model lm_u (.ref_clk_in, .link_req_out(link_req_in));
  initial forever #10 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    if (req_valid_out === 1'b1) got.push_back({req_type_out, req_speed_out, req_payload_out});
    if (tx_prefix_out === 1'b1) n_null++;
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic req_is(input logic [17:0] exp, input logic [17:0] msk, input string m);
    logic [17:0] r;
    r = got.size() ? got.pop_front() : 'x;
    chk((r & msk) === exp, m);
  endtask : req_is
  task automatic t_speed;
    logic [1:0] cs[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    logic [1:0] ex[4] = '{2'h1, 2'h1, 2'h2, 2'h0};
    chk(selfid_sp_out === `PLC_LSPD_RESET, "self-ID reset");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_in);
      lspd_wr_in <= 1'b1;
      lspd_wdata_in <= cs[i];
      arb_accel_enable_in <= i[0];
      multispeed_concat_enable_in <= i[1];
      @(posedge ref_clk_in);
      lspd_wr_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      chk(selfid_sp_out === ex[i], "self-ID speed");
      chk(peer_speed_out === `PLC_SPD_S400, "peer speed");
      chk({arb_accel_active_out, multispeed_concat_active_out} === {i[0], i[1]}, "en");
    end
    $display("test speed done");
  endtask : t_speed
  task automatic t_rx;
    logic [7:0] ds[3] = '{8'h00, 8'hff, 8'h5a};
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk_in);
      rx_valid_in <= 1'b1;
      rx_data_in <= ds[i];
      @(posedge ref_clk_in);
      rx_valid_in <= 1'b0;
      #1 chk(link_rx_valid_out === 1'b1 && link_rx_data_out === ds[i], "rx pass");
    end
    $display("test rx done");
  endtask : t_rx
  task automatic t_requests;
    int n;
    lm_u.send(17'h00049, 7);
    lm_u.send(17'h1c5a3, 17);
    lm_u.idle();
    repeat (8) @(posedge ref_clk_in);
    req_is({`PLC_TYPE_BUS, 3'h1, 12'h0}, 18'h3f000, "legacy bus");
    req_is({`PLC_TYPE_WRREG, 3'h0, 12'h5a3}, 18'h38fff, "write after bus");
    ext_req_mode_in <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      n = n_null;
      lm_u.send(17'h00090 | 17'(s), 8);
      lm_u.idle();
      repeat (8) @(posedge ref_clk_in);
      req_is({`PLC_TYPE_BUS, s[2:0], 12'h0}, 18'h3f000, "extended bus");
      chk((n_null - n) == (s > 2), "null packet count");
    end
    $display("test requests done");
  endtask : t_requests
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1 t_speed();
    t_rx();
    t_requests();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge ref_clk_in);
    n_errors++;
    report_and_stop();
  end
endmodule : tb_phy_link_compat_and_speed_report
